// ===== include/smm_pkg.sv
// constants for the safety motion monitor
package smm_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NCH = 4;
  localparam int NTMR = NCH + 2;
  // register byte addresses
  localparam logic [7:0] A_STATUS = 8'h40;
  localparam logic [7:0] A_MASK = 8'h44;
  localparam logic [7:0] A_STATE = 8'h48;
  localparam logic [7:0] A_RELEASE = 8'h4C;
  // configuration word indices, byte address is four times the index
  localparam int C_UNIT = 0;
  localparam int C_FILT = 1;
  localparam int C_LOWTHR = 2;
  localparam int C_HYST = 3;
  localparam int C_POSDLY = 4;
  localparam int C_NEGDLY = 5;
  localparam int C_DIST = 6;
  localparam int C_SPEED0 = 8;
  localparam int C_DECEL0 = 12;
  localparam int NCFG = 16;
  // reset values
  localparam logic [15:0] DLY_RST = 16'h03E8;
  localparam logic [15:0] SPEED_RST = 16'h0032;
  localparam logic [15:0] HYST_RST = 16'h0014;
  localparam logic [15:0] DIST_RST = 16'h0003;
  localparam logic [15:0] ZERO_RST = 16'h0000;
  // legal maxima
  localparam logic [15:0] SPEED_MAX = 16'h2710;
  localparam logic [15:0] DLY_MAX = 16'hEA60;
  localparam logic [15:0] FILT_MAX = 16'h07D0;
  localparam logic [15:0] DIST_MAX = 16'h03E8;
  localparam logic [15:0] UNIT_MAX = 16'h0002;
  // distance unit scale to hundredths of a revolution
  localparam logic [6:0] SCALE_REV = 7'h64;
  localparam logic [6:0] SCALE_TENTH = 7'h0A;
  localparam logic [6:0] SCALE_HUND = 7'h01;
  // status bits
  localparam int S_SPEED = 0;
  localparam int S_STAND = 1;
  localparam int S_DIR = 2;
  localparam int S_PERR = 3;
  localparam int NSTAT = 4;
  typedef enum logic [1:0] {UNIT_REV, UNIT_TENTH, UNIT_HUND} dist_unit_t;
endpackage

// ===== rtl/safety_motion_monitor.sv
// per-axis safety speed, standstill and direction monitor
// What this block does
// - unit field: revs, tenths or hundredths
// - speed check waits per-channel decel time
// - active speed check cuts torque above limit
// - four channels, own speed and delay
// - standstill overrun judged through delay filter
// - filter delays the standstill torque cutoff
// - indicator off above threshold, on below
// - hysteresis width on indicator comparison
// - alarm forces the indicator off
// - hysteresis above threshold raises range error
// - positive guard waits its own delay
// - negative guard waits its own delay
// - invalid threshold raises range error
// - standstill travel beyond distance cuts torque
`timescale 1ns/1ps
`default_nettype none
module safety_motion_monitor #(
  parameter int TICK_CYC = smm_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic signed [15:0] motor_speed,
  input wire logic signed [31:0] pos_travel,
  input wire logic [3:0] limited_speed_cmd,
  input wire logic positive_direction_guard_cmd,
  input wire logic negative_direction_guard_cmd,
  input wire logic standstill_position_monitor,
  input wire logic safety_disable_alarm,
  output logic torque_cutoff,
  output logic low_speed_indicator,
  output logic safety_param_range_error,
  output logic irq
);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int NT = smm_pkg::NTMR;
  localparam int NC = smm_pkg::NCH;
  localparam int NS = smm_pkg::NSTAT;

  if (TICK_CYC < 1) begin : g_chk
    $error("tick length must be at least one cycle");
  end

  // 1 ms tick
  logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
  logic tick;
  always_comb begin
    tick = (tick_cnt_r == TW'(TICK_CYC - 1));
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) tick_cnt_r <= '0;
    else tick_cnt_r <= tick_cnt_nxt;
  end

  // configuration words
  logic [15:0] cfg_r [smm_pkg::NCFG];
  logic [15:0] cfg_nxt [smm_pkg::NCFG];
  logic [15:0] cfg_rst [smm_pkg::NCFG];
  always_comb begin
    for (int k = 0; k < smm_pkg::NCFG; k++) begin
      cfg_rst[k] = smm_pkg::ZERO_RST;
      cfg_nxt[k] = cfg_r[k];
    end
    cfg_rst[smm_pkg::C_LOWTHR] = smm_pkg::SPEED_RST;
    cfg_rst[smm_pkg::C_HYST] = smm_pkg::HYST_RST;
    cfg_rst[smm_pkg::C_POSDLY] = smm_pkg::DLY_RST;
    cfg_rst[smm_pkg::C_NEGDLY] = smm_pkg::DLY_RST;
    cfg_rst[smm_pkg::C_DIST] = smm_pkg::DIST_RST;
    for (int k = 0; k < NC; k++) begin
      cfg_rst[smm_pkg::C_SPEED0 + k] = smm_pkg::SPEED_RST;
      cfg_rst[smm_pkg::C_DECEL0 + k] = smm_pkg::DLY_RST;
    end
    if (reg_wr && !reg_addr[7] && !reg_addr[6])
      cfg_nxt[reg_addr[5:2]] = reg_wdata[15:0];
  end
  always_ff @(posedge clk) begin
    for (int k = 0; k < smm_pkg::NCFG; k++) begin
      if (sys_rst) cfg_r[k] <= cfg_rst[k];
      else cfg_r[k] <= cfg_nxt[k];
    end
  end

  // absolute speed
  logic [15:0] spd_abs;
  always_comb spd_abs = motor_speed[15] ? 16'(-motor_speed) : 16'(motor_speed);

  // delay timers: limited-speed channels, then positive and negative guard
  logic [NT-1:0] tcmd, tcmd_d_r, trise, tact, tover;
  logic [15:0] tcnt_r [NT];
  logic [15:0] tcnt_nxt [NT];
  logic [15:0] tdly [NT];
  always_comb begin
    tcmd = {negative_direction_guard_cmd, positive_direction_guard_cmd, limited_speed_cmd};
  end
  for (genvar i = 0; i < NT; i++) begin : g_tmr
    // indices stay in range for the guard timers too
    localparam int DI = (i < NC) ? smm_pkg::C_DECEL0 + i : smm_pkg::C_DECEL0;
    localparam int SI = (i < NC) ? smm_pkg::C_SPEED0 + i : smm_pkg::C_SPEED0;
    always_comb begin
      if (i < NC) tdly[i] = cfg_r[DI];
      else if (i == NC) tdly[i] = cfg_r[smm_pkg::C_POSDLY];
      else tdly[i] = cfg_r[smm_pkg::C_NEGDLY];
      trise[i] = tcmd[i] && !tcmd_d_r[i];
      if (trise[i]) tcnt_nxt[i] = '0;
      else if (tcmd[i] && tick && tcnt_r[i] < tdly[i]) tcnt_nxt[i] = tcnt_r[i] + 16'h0001;
      else tcnt_nxt[i] = tcnt_r[i];
      tact[i] = tcmd[i] && !trise[i] && tcnt_r[i] >= tdly[i];
      if (i < NC) tover[i] = tact[i] && spd_abs > cfg_r[SI];
      else if (i == NC) tover[i] = tact[i] && !motor_speed[15] && |motor_speed;
      else tover[i] = tact[i] && motor_speed[15];
    end
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        tcmd_d_r[i] <= 1'b0;
        tcnt_r[i] <= '0;
      end else begin
        tcmd_d_r[i] <= tcmd[i];
        tcnt_r[i] <= tcnt_nxt[i];
      end
    end
  end

  // standstill travel with delay filter
  logic [16:0] ss_limit;
  logic [31:0] pos_abs;
  logic [6:0] ss_scale;
  logic ss_out, ss_trip;
  logic [15:0] ss_cnt_r, ss_cnt_nxt;
  always_comb begin
    unique case (cfg_r[smm_pkg::C_UNIT][1:0])
      smm_pkg::UNIT_REV: ss_scale = smm_pkg::SCALE_REV;
      smm_pkg::UNIT_TENTH: ss_scale = smm_pkg::SCALE_TENTH;
      smm_pkg::UNIT_HUND: ss_scale = smm_pkg::SCALE_HUND;
      default: ss_scale = smm_pkg::SCALE_HUND;
    endcase
    ss_limit = 17'(cfg_r[smm_pkg::C_DIST][9:0] * ss_scale);
    pos_abs = pos_travel[31] ? 32'(-pos_travel) : 32'(pos_travel);
    ss_out = standstill_position_monitor && pos_abs > 32'(ss_limit);
    if (!ss_out) ss_cnt_nxt = '0;
    else if (tick && ss_cnt_r < cfg_r[smm_pkg::C_FILT]) ss_cnt_nxt = ss_cnt_r + 16'h0001;
    else ss_cnt_nxt = ss_cnt_r;
    ss_trip = ss_out && ss_cnt_r >= cfg_r[smm_pkg::C_FILT];
  end
  always_ff @(posedge clk) begin
    if (sys_rst) ss_cnt_r <= '0;
    else ss_cnt_r <= ss_cnt_nxt;
  end

  // parameter check
  logic perr;
  always_comb begin
    perr = cfg_r[smm_pkg::C_HYST] > cfg_r[smm_pkg::C_LOWTHR];
    perr = perr || cfg_r[smm_pkg::C_LOWTHR] > smm_pkg::SPEED_MAX;
    perr = perr || cfg_r[smm_pkg::C_HYST] > smm_pkg::SPEED_MAX;
    perr = perr || cfg_r[smm_pkg::C_UNIT] > smm_pkg::UNIT_MAX;
    perr = perr || cfg_r[smm_pkg::C_DIST] > smm_pkg::DIST_MAX;
    perr = perr || cfg_r[smm_pkg::C_FILT] > smm_pkg::FILT_MAX;
    perr = perr || cfg_r[smm_pkg::C_POSDLY] > smm_pkg::DLY_MAX;
    perr = perr || cfg_r[smm_pkg::C_NEGDLY] > smm_pkg::DLY_MAX;
    for (int k = 0; k < NC; k++) begin
      perr = perr || cfg_r[smm_pkg::C_SPEED0 + k] > smm_pkg::SPEED_MAX;
      perr = perr || cfg_r[smm_pkg::C_DECEL0 + k] > smm_pkg::DLY_MAX;
    end
  end

  // cutoff, indicator, status, mask, read data
  logic cut_r, cut_nxt, ind_r, ind_nxt, perr_r, release_wr, spd_trip, dir_trip;
  logic [NS-1:0] stat_r, stat_nxt, mask_r, mask_nxt, ev;
  logic [31:0] rdata_r, rdata_nxt;
  logic [16:0] low_sum;
  always_comb begin
    spd_trip = |tover[NC-1:0];
    dir_trip = |tover[NT-1:NC];
    release_wr = reg_wr && reg_addr == smm_pkg::A_RELEASE && reg_wdata[0];
    cut_nxt = (cut_r && !release_wr) || spd_trip || ss_trip || dir_trip;
    low_sum = {1'b0, spd_abs} + {1'b0, cfg_r[smm_pkg::C_HYST]};
    if (safety_disable_alarm || perr_r) ind_nxt = 1'b0;
    else if (ind_r) ind_nxt = spd_abs <= cfg_r[smm_pkg::C_LOWTHR];
    else ind_nxt = low_sum < {1'b0, cfg_r[smm_pkg::C_LOWTHR]};
    ev = '0;
    ev[smm_pkg::S_SPEED] = spd_trip;
    ev[smm_pkg::S_STAND] = ss_trip;
    ev[smm_pkg::S_DIR] = dir_trip;
    ev[smm_pkg::S_PERR] = perr;
    stat_nxt = stat_r;
    if (reg_wr && reg_addr == smm_pkg::A_STATUS) stat_nxt = stat_r & ~reg_wdata[NS-1:0];
    stat_nxt = stat_nxt | ev;
    mask_nxt = mask_r;
    if (reg_wr && reg_addr == smm_pkg::A_MASK) mask_nxt = reg_wdata[NS-1:0];
    rdata_nxt = '0;
    if (reg_rd) begin
      if (!reg_addr[7] && !reg_addr[6]) rdata_nxt = {16'h0000, cfg_r[reg_addr[5:2]]};
      else if (reg_addr == smm_pkg::A_STATUS) rdata_nxt = 32'(stat_r);
      else if (reg_addr == smm_pkg::A_MASK) rdata_nxt = 32'(mask_r);
      else if (reg_addr == smm_pkg::A_STATE) rdata_nxt = 32'({tact, perr_r, ind_r, cut_r});
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cut_r <= 1'b0;
      ind_r <= 1'b0;
      perr_r <= 1'b0;
      stat_r <= '0;
      mask_r <= '0;
      rdata_r <= '0;
    end else begin
      cut_r <= cut_nxt;
      ind_r <= ind_nxt;
      perr_r <= perr;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign torque_cutoff = cut_r;
  assign low_speed_indicator = ind_r;
  assign safety_param_range_error = perr_r;
  assign irq = |(stat_r & mask_r);
  assign reg_rdata = rdata_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  cut_hold_a: assert property (cut_r && !release_wr |=> torque_cutoff)
    else $error("torque cutoff dropped without release");
  speed_trip_a: assert property (tact[0] && spd_abs > cfg_r[smm_pkg::C_SPEED0] |=> torque_cutoff)
    else $error("overspeed did not cut torque");
  decel_wait_a: assert property ($rose(limited_speed_cmd[0]) && |cfg_r[smm_pkg::C_DECEL0] ##1 limited_speed_cmd[0]
    |-> !tact[0])
    else $error("speed check started without delay");
  pos_wait_a: assert property ($rose(positive_direction_guard_cmd) && |cfg_r[smm_pkg::C_POSDLY]
    ##1 positive_direction_guard_cmd |-> !tover[NC])
    else $error("direction check started without delay");
  filt_wait_a: assert property (ss_out && ss_cnt_r < cfg_r[smm_pkg::C_FILT] |-> !ss_trip)
    else $error("standstill trip ignored filter");
  ind_force_a: assert property (safety_disable_alarm |=> !low_speed_indicator)
    else $error("indicator on during alarm");
  ind_high_a: assert property (spd_abs > cfg_r[smm_pkg::C_LOWTHR] |=> !low_speed_indicator)
    else $error("indicator on above threshold");
  hyst_err_a: assert property (cfg_r[smm_pkg::C_HYST] > cfg_r[smm_pkg::C_LOWTHR] |=> safety_param_range_error)
    else $error("range error missing");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  cut_speed_c: cover property (spd_trip ##1 torque_cutoff);
  cut_stand_c: cover property (ss_trip && |cfg_r[smm_pkg::C_FILT]);
  ind_on_c: cover property (!low_speed_indicator ##1 low_speed_indicator);
  dir_trip_c: cover property (dir_trip);
endmodule
`default_nettype wire

// ===== verification/motion_ctrl_model.sv
// motion controller model driving the motor speed
`timescale 1ns/1ps
`default_nettype none
module motion_ctrl_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic signed [15:0] target,
  input wire logic slow,
  output logic signed [15:0] motor_speed
);
  logic signed [15:0] spd_nxt;
  // ramps down by a fixed step when slow, else jumps to target
  always_comb begin
    spd_nxt = target;
    if (slow && motor_speed > target + 16'sh0080) begin
      spd_nxt = motor_speed - 16'sh0080;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      motor_speed <= 16'sh0000;
    end else begin
      motor_speed <= spd_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== verification/test_safety_motion_monitor.sv
// bench for the safety motion monitor
`timescale 1ns/1ps
`default_nettype none
module test_safety_motion_monitor;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic slow = 1'b0;
  logic pos_cmd = 1'b0;
  logic neg_cmd = 1'b0;
  logic stand = 1'b0;
  logic alarm = 1'b0;
  logic [3:0] lim_cmd = 4'h0;
  logic signed [15:0] target = 16'sh0000;
  logic signed [31:0] pos_travel = 32'sh0;
  logic [31:0] reg_rdata, rd_v;
  logic signed [15:0] motor_speed;
  logic torque_cutoff, low_speed_indicator, safety_param_range_error, irq;
  int miscompares = 0;
  int n_checks = 0;
  int i;
  logic [7:0] ra [6] = '{8'h08, 8'h0C, 8'h30, 8'h18, 8'h04, 8'h50};
  logic [15:0] rv [6] = '{16'h0032, 16'h0014, 16'h03E8, 16'h0003, 16'h0000, 16'h0000};
  logic signed [15:0] sp [7] = '{16'sh0, 16'sh32, 16'sh33, 16'sh28, 16'sh1D, -16'sh33, -16'sh1D};
  logic [6:0] ind = 7'h53;
  logic [7:0] ea [3] = '{8'h0C, 8'h08, 8'h00};
  logic [15:0] eb [3] = '{16'h0033, 16'h2711, 16'h0003};
  logic [15:0] eg [3] = '{16'h0014, 16'h0032, 16'h0000};
  int dl [3] = '{300, 30, 3};
  initial forever #2 clk = ~clk;
  safety_motion_monitor #(.TICK_CYC(4)) u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .motor_speed(motor_speed), .pos_travel(pos_travel), .limited_speed_cmd(lim_cmd),
    .positive_direction_guard_cmd(pos_cmd), .negative_direction_guard_cmd(neg_cmd),
    .standstill_position_monitor(stand), .safety_disable_alarm(alarm), .torque_cutoff(torque_cutoff),
    .low_speed_indicator(low_speed_indicator), .safety_param_range_error(safety_param_range_error), .irq(irq));
  motion_ctrl_model u_ctrl (.clk(clk), .sys_rst(sys_rst), .target(target), .slow(slow),
    .motor_speed(motor_speed));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic trip(input int early, input int late);
    cyc(early);
    chk(torque_cutoff, 32'h0, "cutoff too early");
    cyc(late);
    chk(torque_cutoff, 32'h1, "cutoff missing");
  endtask
  task automatic release_all;
    @(posedge clk);
    lim_cmd <= 4'h0;
    pos_cmd <= 1'b0;
    neg_cmd <= 1'b0;
    stand <= 1'b0;
    slow <= 1'b0;
    pos_travel <= 32'sh0;
    target <= 16'sh0000;
    wr(8'h4C, 32'h1);
    wr(8'h40, 32'hF);
    cyc(1);
    chk(torque_cutoff, 32'h0, "release");
    chk(irq, 32'h0, "irq clear");
  endtask
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 6; i++) begin
      rd(ra[i], rd_v);
      chk(rd_v, 32'(rv[i]), "reset value");
    end
    wr(8'h44, 32'hF);
    for (i = 0; i < 4; i++) begin
      wr(8'(32 + 4 * i), 32'(100 * i + 100));
      wr(8'(48 + 4 * i), 32'(2 * i + 2));
      @(posedge clk);
      target <= 16'(((i % 2) == 1 ? -1 : 1) * (100 * i + 101));
      lim_cmd <= 4'(1 << i);
      trip(8 * i + 2, 14);
      chk(irq, 32'h1, "irq");
      release_all();
      @(posedge clk);
      target <= 16'(100 * i + 100);
      lim_cmd <= 4'(1 << i);
      cyc(8 * i + 20);
      chk(torque_cutoff, 32'h0, "at limit");
      release_all();
    end
    @(posedge clk);
    target <= 16'sh0190;
    cyc(2);
    @(posedge clk);
    slow <= 1'b1;
    target <= 16'sh0000;
    lim_cmd <= 4'h1;
    cyc(24);
    chk(torque_cutoff, 32'h0, "slowed in time");
    release_all();
    for (i = 0; i < 7; i++) begin
      @(posedge clk);
      target <= sp[i];
      cyc(3);
      chk(low_speed_indicator, 32'(ind[i]), "indicator");
    end
    @(posedge clk);
    alarm <= 1'b1;
    cyc(2);
    chk(low_speed_indicator, 32'h0, "alarm");
    @(posedge clk);
    alarm <= 1'b0;
    for (i = 0; i < 3; i++) begin
      wr(ea[i], 32'(eb[i]));
      cyc(2);
      chk(safety_param_range_error, 32'h1, "range error");
      chk(low_speed_indicator, 32'h0, "forced off");
      wr(ea[i], 32'(eg[i]));
      cyc(2);
      chk(safety_param_range_error, 32'h0, "range ok");
    end
    wr(8'h04, 32'h2);
    for (i = 0; i < 3; i++) begin
      wr(8'h00, 32'(i));
      @(posedge clk);
      stand <= 1'b1;
      pos_travel <= 32'(dl[i]);
      cyc(20);
      chk(torque_cutoff, 32'h0, "in distance");
      @(posedge clk);
      pos_travel <= -32'(dl[i] + 1);
      trip(2, 12);
      release_all();
    end
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h5);
    @(posedge clk);
    target <= 16'sh000A;
    pos_cmd <= 1'b1;
    trip(2, 12);
    release_all();
    @(posedge clk);
    target <= -16'sh000A;
    neg_cmd <= 1'b1;
    trip(14, 14);
    release_all();
    print_verdict();
  end
endmodule
`default_nettype wire
